// ---- pkg/hioc_pkg.sv ----
// package: constants and types for the host interrupt output stage
package hioc_pkg;

   // ==========================================================
   // bus widths and register offsets
   localparam int HIOC_ADDR_W = 8;
   localparam int HIOC_DATA_W = 32;
   localparam logic [7:0] HIOC_OFS_ID = 8'h50;
   localparam logic [7:0] HIOC_OFS_CFG = 8'h54;
   localparam logic [7:0] HIOC_OFS_STS = 8'h58;
   localparam logic [7:0] HIOC_OFS_EN = 8'h5c;

   // ==========================================================
   // field positions of the interrupt output configuration and status registers
   localparam int HIOC_CFG_IVL_LSB = 24;
   localparam int HIOC_CFG_RESTART = 14;
   localparam int HIOC_CFG_ACTIVE = 13;
   localparam int HIOC_CFG_MASTER = 12;
   localparam int HIOC_CFG_OUT_EN = 8;
   localparam int HIOC_CFG_POL = 4;
   localparam int HIOC_CFG_BTYPE = 0;
   localparam int HIOC_STS_WAKE = 17;
   localparam logic [31:0] HIOC_WAKE_MASK = 32'h0002_0000;

   // ==========================================================
   // reset values
   localparam logic [31:0] HIOC_CFG_RST = 32'h0000_0000;
   localparam logic [31:0] HIOC_STS_RST = 32'h0000_0000;
   localparam logic [31:0] HIOC_EN_RST = 32'h0000_0000;

   // ==========================================================
   // holdoff timing: a least time, so the cycle count rounds up
   localparam int HIOC_UNIT_NS = 10000;
   localparam int HIOC_CLK_NS = 4;
   localparam int HIOC_UNIT_CYC = (HIOC_UNIT_NS + HIOC_CLK_NS - 1)
                                  / HIOC_CLK_NS;
   localparam logic [11:0] HIOC_UNIT_LAST = 12'(HIOC_UNIT_CYC - 1);

   // ==========================================================
   // pin synchroniser layout: strobes, address, data
   localparam int HIOC_SYNC_W = 3 + HIOC_ADDR_W + HIOC_DATA_W;
   localparam int HIOC_SYNC_CS = 42;
   localparam int HIOC_SYNC_RD = 41;
   localparam int HIOC_SYNC_WR = 40;
   localparam int HIOC_SYNC_ADDR = 32;
   localparam logic [42:0] HIOC_SYNC_RST = {3'h7, 40'h00_0000_0000};

   // ==========================================================
   // state types
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_RD = 2'b01,
      BUS_WAIT = 2'b11
   } hioc_bus_e;

   typedef enum logic [0:0] {
      HOLD_IDLE = 1'b0,
      HOLD_RUN = 1'b1
   } hioc_hold_e;

   typedef struct packed {
      hioc_hold_e state;
      logic [11:0] pre;
      logic [7:0] units;
      logic [7:0] limit;
      logic [19:0] elapsed;
   } hioc_hold_s;

   localparam hioc_hold_s HIOC_HOLD_RST = '{HOLD_IDLE, 12'h000, 8'h00,
                                            8'h00, 20'h0_0000};

   typedef struct packed {
      logic [42:0] sync1;
      logic [42:0] sync2;
      hioc_bus_e bus;
      logic [31:0] rdata;
      logic data_oe_n;
      logic [7:0] interval;
      logic restart;
      logic out_en;
      logic pol;
      logic btype;
      logic [31:0] sts;
      logic [31:0] en;
      logic main_del;
      logic pin_asserted;
      logic irq_o;
      logic irq_oe_n;
   } hioc_top_s;

endpackage : hioc_pkg

// ---- pkg/hioc_holdoff_if.sv ----
// interface: holdoff control between register block and interval timer
`timescale 1ns/100ps
interface hioc_holdoff_if;
   logic [7:0] interval;
   logic restart;
   logic start;
   logic active;

   modport ctl (output interval, output restart, output start,
                input active);
   modport cnt (input interval, input restart, input start,
                output active);
endinterface : hioc_holdoff_if

// ---- verilog/hioc_holdoff.sv ----
// module: deassertion holdoff interval timer
`timescale 1ns/100ps
module hioc_holdoff (
   input wire logic ref_clk,
   input wire logic rst,
   hioc_holdoff_if.cnt hif
);
   import hioc_pkg::*;

   hioc_hold_s st_r;
   hioc_hold_s st_nxt;
   logic expire;

   // ==========================================================
   // next state
   always_comb begin
      st_nxt = st_r;
      expire = 1'b0;
      if (hif.interval == 8'h00) begin
         // zero field: interval off, counter cleared R02
         st_nxt.state = HOLD_IDLE;
         st_nxt.pre = 12'h000;
         st_nxt.units = 8'h00;
      end else if (hif.restart || hif.start) begin
         // field is latched so a later nonzero write only affects new intervals
         st_nxt.state = HOLD_RUN; // R05 R03
         st_nxt.pre = 12'h000;
         st_nxt.units = 8'h00;
         st_nxt.limit = hif.interval; // R03
         st_nxt.elapsed = 20'h0_0000;
      end else begin
         case (st_r.state)
            HOLD_RUN: begin
               st_nxt.elapsed = st_r.elapsed + 20'h0_0001;
               if (st_r.pre == HIOC_UNIT_LAST) begin // R01
                  st_nxt.pre = 12'h000;
                  if (st_r.units == st_r.limit - 8'h01) begin
                     expire = 1'b1;
                     st_nxt.state = HOLD_IDLE;
                     st_nxt.units = 8'h00;
                  end else begin
                     st_nxt.units = st_r.units + 8'h01;
                  end
               end else begin
                  st_nxt.pre = st_r.pre + 12'h001;
               end
            end
            default: begin
               st_nxt.state = HOLD_IDLE;
            end
         endcase
      end
   end

   assign hif.active = (st_r.state == HOLD_RUN); // R06

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_r <= HIOC_HOLD_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // checks
   a_zero_stops: assert property ( // R02
      @(posedge ref_clk) disable iff (rst)
      (hif.interval == 8'h00) |=> !hif.active)
      else $error("holdoff still running after zero interval");

   a_restart_fresh: assert property ( // R05
      @(posedge ref_clk) disable iff (rst)
      (hif.restart && hif.interval != 8'h00) |=>
      (hif.active && st_r.pre == 12'h000 && st_r.units == 8'h00))
      else $error("restart did not begin a fresh interval");

   a_interval_length: assert property ( // R01
      @(posedge ref_clk) disable iff (rst)
      expire |-> (st_r.elapsed ==
                  (20'(st_r.limit) * 20'(HIOC_UNIT_CYC) - 20'h0_0001)))
      else $error("holdoff interval length wrong");

   a_limit_latched: assert property ( // R03
      @(posedge ref_clk) disable iff (rst)
      (hif.start && hif.interval != 8'h00) |=>
      (st_r.limit == $past(hif.interval)))
      else $error("new interval value not taken at start");

endmodule : hioc_holdoff

// ---- verilog/hioc_top.sv ----
// module: host interrupt output stage with its configuration registers
//
// Functional notes
// R01 - The holdoff interval field in config bits 31:24 counts units of 10 us.
// R02 - Writing the field as zero stops the interval, clears the counter, frees pending requests.
// R03 - A new nonzero field value governs every interval started after the write.
// R04 - The wake event interrupt is never held back by the holdoff interval.
// R05 - Writing one to self-clearing bit 14 restarts the interval from zero at any time.
// R06 - Bit 13 reads high while an interval runs, and requests are withheld from the pin then.
// R07 - Bit 12 shows the combined enabled request, ignoring output enable and holdoff.
// R08 - With output enable bit 8 clear the pin stays deasserted, status still works.
// R09 - Polarity bit 4 clear makes the pin active low, set makes it active high.
// R10 - Buffer type bit 0 clear gives open drain, set gives push-pull.
// R11 - In open drain mode polarity is ignored and the asserted pin is driven low.
// R12 - Polarity and buffer type survive soft reset and clear only on hard reset.
// R13 - The identity register holds a 16-bit design code over a 16-bit revision.
// R14 - Identity sits at 50h, config at 54h, status at 58h, enable at 5Ch.
// R15 - When an interval ends with a request pending the pin asserts on the next clock.
`timescale 1ns/100ps
module hioc_top #(
   parameter logic [15:0] CHIP_ID = 16'h5a5a,   // arbitrary value
   parameter logic [15:0] REVISION = 16'h0001   // arbitrary value
) (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic SOFT_RST,
   input wire logic CS_N,
   input wire logic RD_N,
   input wire logic WR_N,
   input wire logic [hioc_pkg::HIOC_ADDR_W-1:0] ADDR,
   input wire logic [hioc_pkg::HIOC_DATA_W-1:0] DATA_IN,
   output logic [hioc_pkg::HIOC_DATA_W-1:0] DATA_OUT,
   output logic DATA_OE_N,
   input wire logic [31:0] INT_SRC,
   output logic IRQ_O,
   output logic IRQ_OE_N
);
   import hioc_pkg::*;

   // ==========================================================
   // state and combinational views
   localparam hioc_top_s TOP_RST = '{
      sync1: HIOC_SYNC_RST,
      sync2: HIOC_SYNC_RST,
      bus: BUS_IDLE,
      rdata: 32'h0000_0000,
      data_oe_n: 1'b1,
      interval: HIOC_CFG_RST[31:24],
      restart: 1'b0,
      out_en: HIOC_CFG_RST[HIOC_CFG_OUT_EN],
      pol: HIOC_CFG_RST[HIOC_CFG_POL],
      btype: HIOC_CFG_RST[HIOC_CFG_BTYPE],
      sts: HIOC_STS_RST,
      en: HIOC_EN_RST,
      main_del: 1'b0,
      pin_asserted: 1'b0,
      irq_o: 1'b0,
      irq_oe_n: 1'b1
   };

   hioc_top_s st;
   hioc_top_s n;

   logic cs;
   logic rd;
   logic wr;
   logic [7:0] addr_w;
   logic [31:0] wdata;
   logic [31:0] clr;
   logic [31:0] cfg_view;
   logic [31:0] rd_mux;
   logic irq_all;
   logic irq_wake;
   logic irq_main;
   logic asserted;

   hioc_holdoff_if hif ();

   hioc_holdoff u_holdoff (
      .ref_clk(REF_CLK),
      .rst(RST),
      .hif(hif)
   );

   // ==========================================================
   // synchronised host strobes, word aligned address
   assign cs = !st.sync2[HIOC_SYNC_CS];
   assign rd = !st.sync2[HIOC_SYNC_RD];
   assign wr = !st.sync2[HIOC_SYNC_WR];
   assign addr_w = {st.sync2[HIOC_SYNC_ADDR+7:HIOC_SYNC_ADDR+2], 2'b00};
   assign wdata = st.sync2[31:0];

   // ==========================================================
   // request combining
   assign irq_all = |(st.sts & st.en); // R07
   assign irq_wake = st.sts[HIOC_STS_WAKE] & st.en[HIOC_STS_WAKE];
   assign irq_main = |(st.sts & st.en & ~HIOC_WAKE_MASK);
   // wake event bypasses the holdoff gate
   assign asserted = st.out_en & (irq_wake | // R04 R08
                     (irq_main & !hif.active)); // R06 R15

   // ==========================================================
   // holdoff hookup: interval starts when the delivered request drops
   assign hif.interval = st.interval;
   assign hif.restart = st.restart;
   assign hif.start = st.main_del & !irq_main;

   // ==========================================================
   // read view
   always_comb begin
      cfg_view = 32'h0000_0000;
      cfg_view[31:24] = st.interval;
      cfg_view[HIOC_CFG_ACTIVE] = hif.active; // R06
      cfg_view[HIOC_CFG_MASTER] = irq_all; // R07
      cfg_view[HIOC_CFG_OUT_EN] = st.out_en;
      cfg_view[HIOC_CFG_POL] = st.pol;
      cfg_view[HIOC_CFG_BTYPE] = st.btype;
   end

   always_comb begin
      case (addr_w) // R14
         HIOC_OFS_ID: rd_mux = {CHIP_ID, REVISION}; // R13
         HIOC_OFS_CFG: rd_mux = cfg_view;
         HIOC_OFS_STS: rd_mux = st.sts;
         HIOC_OFS_EN: rd_mux = st.en;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // ==========================================================
   // next state
   always_comb begin
      n = st;
      clr = 32'h0000_0000;
      n.sync1 = {CS_N, RD_N, WR_N, ADDR, DATA_IN};
      n.sync2 = st.sync1;
      n.restart = 1'b0;

      case (st.bus)
         BUS_IDLE: begin
            if (cs && wr) begin
               n.bus = BUS_WAIT;
               case (addr_w) // R14
                  HIOC_OFS_CFG: begin
                     n.interval = wdata[31:24]; // R01 R02 R03
                     n.restart = wdata[HIOC_CFG_RESTART]; // R05
                     n.out_en = wdata[HIOC_CFG_OUT_EN]; // R08
                     n.pol = wdata[HIOC_CFG_POL]; // R09
                     n.btype = wdata[HIOC_CFG_BTYPE]; // R10
                  end
                  HIOC_OFS_STS: begin
                     clr = wdata;
                  end
                  HIOC_OFS_EN: begin
                     n.en = wdata;
                  end
                  default: begin
                     n.bus = BUS_WAIT;
                  end
               endcase
            end else if (cs && rd) begin
               n.bus = BUS_RD;
               n.rdata = rd_mux;
               n.data_oe_n = 1'b0;
            end
         end
         BUS_RD: begin
            // data held steady for the whole strobe, no refresh
            if (!cs || !rd) begin
               n.bus = BUS_IDLE;
               n.data_oe_n = 1'b1;
            end
         end
         BUS_WAIT: begin
            if (!cs || !wr) begin
               n.bus = BUS_IDLE;
            end
         end
         default: begin
            n.bus = BUS_IDLE;
            n.data_oe_n = 1'b1;
         end
      endcase

      // new source events win over a same-cycle clear
      n.sts = (st.sts & ~clr) | INT_SRC;

      n.main_del = irq_main & !hif.active;
      n.pin_asserted = asserted;
      if (st.btype) begin
         n.irq_oe_n = 1'b0; // R10
         n.irq_o = asserted ? st.pol : !st.pol; // R09
      end else begin
         // open drain: polarity ignored, only ever pulls low
         n.irq_oe_n = !asserted; // R10 R11
         n.irq_o = 1'b0; // R11
      end

      if (SOFT_RST) begin
         // polarity and buffer type deliberately kept
         n.interval = 8'h00; // R12
         n.restart = 1'b0;
         n.out_en = 1'b0;
         n.sts = HIOC_STS_RST;
         n.en = HIOC_EN_RST;
         n.main_del = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         st <= TOP_RST;
      end else begin
         st <= n;
      end
   end

   assign DATA_OUT = st.rdata;
   assign DATA_OE_N = st.data_oe_n;
   assign IRQ_O = st.irq_o;
   assign IRQ_OE_N = st.irq_oe_n;

   // ==========================================================
   // checks
   a_pin_disabled: assert property ( // R08
      @(posedge REF_CLK) disable iff (RST)
      !st.out_en |=> !st.pin_asserted)
      else $error("pin asserted while output disabled");

   a_open_drain_low: assert property ( // R11
      @(posedge REF_CLK) disable iff (RST)
      (st.pin_asserted && !$past(st.btype)) |->
      (!IRQ_OE_N && !IRQ_O))
      else $error("open drain pin not pulled low");

   a_open_drain_idle: assert property ( // R10
      @(posedge REF_CLK) disable iff (RST)
      (!st.pin_asserted && !$past(st.btype)) |-> IRQ_OE_N)
      else $error("open drain pin driven while idle");

   a_push_pull_level: assert property ( // R09
      @(posedge REF_CLK) disable iff (RST)
      $past(st.btype) |->
      (!IRQ_OE_N && IRQ_O == (st.pin_asserted ~^ $past(st.pol))))
      else $error("push-pull level does not follow polarity");

   a_holdoff_blocks: assert property ( // R06
      @(posedge REF_CLK) disable iff (RST)
      (hif.active && !irq_wake) |=> !st.pin_asserted)
      else $error("request reached pin during holdoff");

   a_wake_bypass: assert property ( // R04
      @(posedge REF_CLK) disable iff (RST)
      (irq_wake && st.out_en) |=> st.pin_asserted)
      else $error("wake event held back");

   a_expiry_release: assert property ( // R15
      @(posedge REF_CLK) disable iff (RST)
      ($fell(hif.active) && irq_main && st.out_en) |=> st.pin_asserted)
      else $error("pending request not delivered after holdoff");

   a_status_sticky: assert property (
      @(posedge REF_CLK) disable iff (RST)
      (!SOFT_RST && INT_SRC != 32'h0000_0000) |=>
      ((st.sts & $past(INT_SRC)) == $past(INT_SRC)))
      else $error("source event lost from status");

   a_master_read: assert property ( // R07
      @(posedge REF_CLK) disable iff (RST)
      (st.bus == BUS_IDLE && cs && rd && !wr && addr_w == HIOC_OFS_CFG)
      |=> (DATA_OUT[HIOC_CFG_MASTER] == $past(irq_all)) && !DATA_OE_N)
      else $error("master bit read wrong");

   a_id_read: assert property ( // R13
      @(posedge REF_CLK) disable iff (RST)
      (st.bus == BUS_IDLE && cs && rd && !wr && addr_w == HIOC_OFS_ID)
      |=> (DATA_OUT == {CHIP_ID, REVISION}))
      else $error("identity read wrong");

   a_soft_keeps: assert property ( // R12
      @(posedge REF_CLK) disable iff (RST)
      SOFT_RST |=> (st.pol == $past(st.pol) && st.btype == $past(st.btype)
                    && st.interval == 8'h00))
      else $error("soft reset disturbed kept bits");

endmodule : hioc_top

// ---- verification/hioc_host_model.sv ----
// host processor model: parallel bus cycles and request line sensing
`timescale 1ns/100ps
module hioc_host_model (
   input wire logic ref_clk,
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic [7:0] addr,
   output logic [31:0] data_in,
   input wire logic [31:0] data_out,
   input wire logic data_oe_n,
   input wire logic irq_o,
   input wire logic irq_oe_n,
   output logic irq_level
);
   // ==========================================================
   // shared request line has a pull-up, so a released pin reads high
   assign irq_level = irq_oe_n ? 1'b1 : irq_o;

   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      addr = 8'h00;
      data_in = 32'h0000_0000;
   end

   // ==========================================================
   // bus cycles; address and write data flip once released, never stale
   task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      cs_n <= 1'b0;
      wr_n <= 1'b0;
      addr <= a;
      data_in <= d;
      repeat (5) @(posedge ref_clk);
      cs_n <= 1'b1;
      wr_n <= 1'b1;
      addr <= ~a;
      data_in <= ~d;
      repeat (4) @(posedge ref_clk);
   endtask : bus_write

   task automatic bus_read(input logic [7:0] a, output logic [31:0] d,
                           output logic ok);
      int n;
      @(posedge ref_clk);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      addr <= a;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (data_oe_n !== 1'b0 && n < 12);
      ok = (n < 12);
      d = data_out;
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      addr <= ~a;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (data_oe_n !== 1'b1 && n < 12);
      repeat (2) @(posedge ref_clk);
   endtask : bus_read
endmodule : hioc_host_model

// ---- verification/tb.sv ----
// testbench: host interrupt output stage against a host model
`timescale 1ns/100ps
module tb;
   import hioc_pkg::*;
   localparam logic [15:0] ID_CODE = 16'h3c96; // arbitrary value
   localparam logic [15:0] REV_CODE = 16'h0007; // arbitrary value
   logic ref_clk = 1'b0;
   logic rst, soft_rst, cs_n, rd_n, wr_n, data_oe_n, irq_o, irq_oe_n;
   logic irq_level;
   logic [7:0] addr;
   logic [31:0] data_in, data_out, int_src, seed;
   int miscompares = 0;
   int checks_done = 0;
   int cyc = 0;

   always #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cyc <= cyc + 1;

   hioc_top #(.CHIP_ID(ID_CODE), .REVISION(REV_CODE)) hioc_top_inst (
      .REF_CLK(ref_clk), .RST(rst), .SOFT_RST(soft_rst), .CS_N(cs_n),
      .RD_N(rd_n), .WR_N(wr_n), .ADDR(addr), .DATA_IN(data_in),
      .DATA_OUT(data_out), .DATA_OE_N(data_oe_n), .INT_SRC(int_src),
      .IRQ_O(irq_o), .IRQ_OE_N(irq_oe_n));

   hioc_host_model hioc_host_model_inst (
      .ref_clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
      .addr(addr), .data_in(data_in), .data_out(data_out),
      .data_oe_n(data_oe_n), .irq_o(irq_o), .irq_oe_n(irq_oe_n),
      .irq_level(irq_level));

   // ==========================================================
   // expectation helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   function automatic logic [31:0] mk(input logic [7:0] ivl,
      input logic r, input logic act, input logic mst, input logic oe,
      input logic pol, input logic bt);
      return {ivl, 9'h000, r, act, mst, 3'h0, oe, 3'h0, pol, 3'h0, bt};
   endfunction : mk

   function automatic logic pin_exp(input logic on, input logic pol,
                                    input logic bt);
      if (!bt) return !on;
      return on ? pol : !pol;
   endfunction : pin_exp

   // bus latency shaves a few cycles off the measured wait
   function automatic logic in_win(input int e, input int u);
      return e >= u * HIOC_UNIT_CYC - 30 && e <= u * HIOC_UNIT_CYC + 10;
   endfunction : in_win

   // ==========================================================
   // checking and stimulus tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic ok;
      hioc_host_model_inst.bus_read(a, d, ok);
      check({31'h0, ok}, 32'h1);
      check(d, exp);
   endtask : rd_chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      hioc_host_model_inst.bus_write(a, d);
   endtask : wr

   task automatic pulse(input logic [4:0] b);
      @(posedge ref_clk);
      int_src <= 32'h1 << b;
      @(posedge ref_clk);
      int_src <= 32'h0;
   endtask : pulse

   task automatic hold_wait(input int t0, input int u);
      while (irq_level !== 1'b0 && cyc - t0 < 6000) @(posedge ref_clk);
      check({31'h0, in_win(cyc - t0, u)}, 32'h1);
   endtask : hold_wait

   task automatic final_report;
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (60000) @(posedge ref_clk);
      miscompares++;
      final_report;
   end

   // ==========================================================
   // main sequence
   initial begin
      logic [4:0] b;
      int t0;
      rst = 1'b1;
      soft_rst = 1'b0;
      int_src = 32'h0;
      seed = 32'h6ee6;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      rd_chk(HIOC_OFS_ID, {ID_CODE, REV_CODE});
      wr(HIOC_OFS_ID, 32'hffff_ffff);
      rd_chk(HIOC_OFS_ID, {ID_CODE, REV_CODE});
      rd_chk(HIOC_OFS_CFG, 32'h0);
      rd_chk(HIOC_OFS_STS, 32'h0);
      rd_chk(8'h60, 32'h0);
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         wr(HIOC_OFS_EN, seed);
         rd_chk(HIOC_OFS_EN, seed);
      end
      $display("test register map done");
      seed = xs(seed);
      b = seed[4:0];
      if (b == 5'd17) b = 5'd3;
      wr(HIOC_OFS_EN, 32'h1 << b);
      for (int m = 0; m < 4; m++) begin
         wr(HIOC_OFS_CFG, mk(8'h00, 0, 0, 0, 1, m[0], m[1]));
         pulse(b);
         repeat (3) @(posedge ref_clk);
         check(irq_level, pin_exp(1'b1, m[0], m[1]));
         check(irq_oe_n, 1'b0);
         rd_chk(HIOC_OFS_CFG, mk(8'h00, 0, 0, 1, 1, m[0], m[1]));
         wr(HIOC_OFS_STS, 32'h1 << b);
         check(irq_level, pin_exp(1'b0, m[0], m[1]));
         check(irq_oe_n, !m[1]);
      end
      wr(HIOC_OFS_CFG, mk(8'h00, 0, 0, 0, 0, 1, 1));
      pulse(b);
      repeat (3) @(posedge ref_clk);
      check(irq_level, 1'b0);
      rd_chk(HIOC_OFS_STS, 32'h1 << b);
      rd_chk(HIOC_OFS_CFG, mk(8'h00, 0, 0, 1, 0, 1, 1));
      wr(HIOC_OFS_STS, 32'h1 << b);
      $display("test pin modes done");
      wr(HIOC_OFS_EN, HIOC_WAKE_MASK | (32'h1 << b));
      for (int u = 1; u < 3; u++) begin
         wr(HIOC_OFS_CFG, mk(u[7:0], 0, 0, 0, 1, 0, 0));
         pulse(b);
         wr(HIOC_OFS_STS, 32'h1 << b);
         t0 = cyc;
         pulse(b);
         repeat (3) @(posedge ref_clk);
         check(irq_level, 1'b1);
         rd_chk(HIOC_OFS_CFG, mk(u[7:0], 0, 1, 1, 1, 0, 0));
         hold_wait(t0, u);
         wr(HIOC_OFS_STS, 32'h1 << b);
         wr(HIOC_OFS_CFG, mk(8'h00, 0, 0, 0, 1, 0, 0));
      end
      $display("test holdoff length done");
      wr(HIOC_OFS_CFG, mk(8'h01, 0, 0, 0, 1, 0, 0));
      pulse(b);
      wr(HIOC_OFS_STS, 32'h1 << b);
      pulse(5'd17);
      repeat (3) @(posedge ref_clk);
      check(irq_level, 1'b0);
      wr(HIOC_OFS_STS, HIOC_WAKE_MASK);
      repeat (1500) @(posedge ref_clk);
      pulse(b);
      wr(HIOC_OFS_CFG, mk(8'h01, 1, 0, 0, 1, 0, 0));
      t0 = cyc;
      hold_wait(t0, 1);
      wr(HIOC_OFS_STS, 32'h1 << b);
      pulse(b);
      repeat (3) @(posedge ref_clk);
      check(irq_level, 1'b1);
      wr(HIOC_OFS_CFG, mk(8'h00, 0, 0, 0, 1, 0, 0));
      check(irq_level, 1'b0);
      rd_chk(HIOC_OFS_CFG, mk(8'h00, 0, 0, 1, 1, 0, 0));
      wr(HIOC_OFS_STS, 32'h1 << b);
      $display("test wake restart zero done");
      wr(HIOC_OFS_CFG, mk(8'h03, 0, 0, 0, 1, 1, 1));
      @(posedge ref_clk);
      soft_rst <= 1'b1;
      @(posedge ref_clk);
      soft_rst <= 1'b0;
      rd_chk(HIOC_OFS_CFG, mk(8'h00, 0, 0, 0, 0, 1, 1));
      rd_chk(HIOC_OFS_EN, 32'h0);
      @(posedge ref_clk);
      rst <= 1'b1;
      @(posedge ref_clk);
      rst <= 1'b0;
      rd_chk(HIOC_OFS_CFG, 32'h0);
      $display("test resets done");
      final_report;
   end
endmodule : tb
